//--- rtl/abcs_pkg.sv
package abcs_pkg;

    // ==========================================================
    // Timing
    // ==========================================================
    localparam int CLK_PERIOD_NS     = 20;
    localparam int DATA_DELAY_NS     = 500;
    localparam int BLANK_DELAY_NS    = 1300;
    localparam int RESTART_MIN_NS    = 2000;
    localparam int DATA_DELAY_CYC    = DATA_DELAY_NS / CLK_PERIOD_NS;
    localparam int BLANK_DELAY_CYC   = BLANK_DELAY_NS / CLK_PERIOD_NS;
    localparam int RESTART_MIN_CYC   = (RESTART_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CYC_DEFAULT  = 1250;
    localparam int TIMER_W           = 16;

    // ==========================================================
    // Data
    // ==========================================================
    localparam int RESULT_W          = 10;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 10'h000;

    // ==========================================================
    // States
    // ==========================================================
    typedef enum logic [4:0] {
        ABCS_STANDBY  = 5'h01,
        ABCS_CONVERT  = 5'h02,
        ABCS_HALTED   = 5'h04,
        ABCS_PRESENT  = 5'h08,
        ABCS_BLANKING = 5'h10
    } abcs_state_type;

endpackage

//--- rtl/abcs_sar_if.sv
`timescale 1ns/10ps
interface abcs_sar_if;
    import abcs_pkg::*;
    logic                start;
    logic                step;
    logic                finished;
    logic [RESULT_W-1:0] result;
    modport ctrl (output start, output step, input finished, input result);
    modport core (input start, input step, output finished, output result);
endinterface

//--- rtl/abcs_sar_core.sv
`timescale 1ns/10ps
module abcs_sar_core #(
    parameter int RESULT_W_P = 10
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        compare_high,
    abcs_sar_if.core         sar
);
    import abcs_pkg::*;

    // ==========================================================
    // Successive approximation register
    // ==========================================================
    logic [RESULT_W_P-1:0] trial_q;
    logic [RESULT_W_P-1:0] bit_q;
    logic                  busy_q;
    wire  [RESULT_W_P-1:0] keep_bits = compare_high ? trial_q : (trial_q & ~bit_q);
    wire                   last_bit  = bit_q[0];

    always_ff @(posedge clk) begin
        if (reset || sar.start) begin
            trial_q <= {1'b1, {(RESULT_W_P-1){1'b0}}};
            bit_q   <= {1'b1, {(RESULT_W_P-1){1'b0}}};
            busy_q  <= sar.start;
        end else if (busy_q && sar.step) begin
            trial_q <= keep_bits | (bit_q >> 1);
            bit_q   <= bit_q >> 1;
            busy_q  <= !last_bit;
        end
    end

    assign sar.finished = busy_q && sar.step && last_bit;
    assign sar.result   = keep_bits;
endmodule

//--- rtl/abcs_sequencer.sv
`timescale 1ns/10ps
// Operation
// - Input high in standby keeps outputs floating and done flag released high.
// - Falling input starts conversion; done flag and data hold their states.
// - At completion done goes low, data driven within 500 ns.
// - About 1.3 us after input rises, done releases and data floats.
// - Input raised mid-conversion halts it; outputs stay unchanged.
// - High pulse of 2 us or more mid-conversion clears and restarts.
// - While input stays low after completion, result is presented indefinitely.
// - Done output is open-collector so several may be wired together.
module abcs_sequencer #(
    parameter int CONV_CYC = abcs_pkg::CONV_CYC_DEFAULT
) (
    input  wire logic                           clk,
    input  wire logic                           reset,
    input  wire logic                           blank_convert_n,
    input  wire logic                           compare_high,
    output logic [abcs_pkg::RESULT_W-1:0]       data_out,
    output logic [abcs_pkg::RESULT_W-1:0]       data_oe_n,
    output logic                                conversion_done_n_out,
    output logic                                conversion_done_n_oe_n
);
    import abcs_pkg::*;

    // ==========================================================
    // Control state
    // ==========================================================
    abcs_state_type       state_q;
    abcs_state_type       state_d;
    logic                 bc_q;
    logic [TIMER_W-1:0]   timer_q;
    logic [TIMER_W-1:0]   step_q;
    logic [TIMER_W-1:0]   high_q;
    logic                 done_q;
    logic                 drive_q;
    logic [RESULT_W-1:0]  result_q;

    abcs_sar_if sar ();

    abcs_sar_core #(
        .RESULT_W_P (RESULT_W)
    ) u_core (
        .clk          (clk),
        .reset        (reset),
        .compare_high (compare_high),
        .sar          (sar.core)
    );

    // ==========================================================
    // Timing constants
    // ==========================================================
    // All waits count whole clocks, so every figure lands on a clock edge.
    localparam logic [TIMER_W-1:0] STEP_CYC  = TIMER_W'(CONV_CYC / RESULT_W);
    localparam logic [TIMER_W-1:0] DATA_LAST = TIMER_W'(DATA_DELAY_CYC);
    localparam logic [TIMER_W-1:0] BLANK_LAST = TIMER_W'(BLANK_DELAY_CYC);
    localparam logic [TIMER_W-1:0] RESTART_LAST = TIMER_W'(RESTART_MIN_CYC);

    // ==========================================================
    // Input edges and counters
    // ==========================================================
    wire fall_edge   = bc_q && !blank_convert_n;
    wire rise_edge   = !bc_q && blank_convert_n;
    wire long_high   = high_q >= RESTART_LAST;
    wire step_now    = (step_q == STEP_CYC - TIMER_W'(1));
    // Data is driven two cycles after done falls, well inside the allowed window.
    wire data_due    = (timer_q >= TIMER_W'(1)) && (timer_q < DATA_LAST);
    wire blank_due   = (timer_q >= BLANK_LAST - TIMER_W'(1));

    // ==========================================================
    // Start decoding
    // ==========================================================
    // Stepping stops as soon as the input rises, so a halt never loses a bit.
    wire in_convert  = (state_q == ABCS_CONVERT);
    wire start_idle  = (state_q == ABCS_STANDBY) && fall_edge;
    wire start_long  = (state_q == ABCS_HALTED) && fall_edge && long_high;
    // A fall while blanking is a fresh command and must reload the approximation.
    wire start_blank = (state_q == ABCS_BLANKING) && !blank_convert_n;

    assign sar.step  = step_now && in_convert && !blank_convert_n;
    // A restart after a long pulse reloads the approximation from scratch.
    assign sar.start = start_idle || start_long || start_blank;

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        state_d = state_q;
        case (state_q)
            ABCS_STANDBY: begin
                if (fall_edge) begin
                    state_d = ABCS_CONVERT;
                end
            end
            ABCS_CONVERT: begin
                if (blank_convert_n) begin
                    state_d = ABCS_HALTED;
                end else if (sar.finished) begin
                    state_d = ABCS_PRESENT;
                end
            end
            ABCS_HALTED: begin
                // A short pulse only resumes; the approximation keeps its progress.
                if (fall_edge) begin
                    state_d = ABCS_CONVERT;
                end
            end
            ABCS_PRESENT: begin
                if (blank_convert_n) begin
                    state_d = ABCS_BLANKING;
                end
            end
            ABCS_BLANKING: begin
                if (!blank_convert_n) begin
                    state_d = ABCS_CONVERT;
                end else if (blank_due) begin
                    state_d = ABCS_STANDBY;
                end
            end
            default: begin
                state_d = ABCS_STANDBY;
            end
        endcase
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= ABCS_STANDBY;
        end else begin
            state_q <= state_d;
        end
    end

    // The stored level starts high, so an input already low at release of reset counts as a fall.
    always_ff @(posedge clk) begin
        if (reset) begin
            bc_q <= 1'b1;
        end else begin
            bc_q <= blank_convert_n;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || state_q != state_d) begin
            timer_q <= '0;
        end else if (timer_q != {TIMER_W{1'b1}}) begin
            timer_q <= timer_q + TIMER_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (reset || sar.start || step_now) begin
            step_q <= '0;
        end else if (state_q == ABCS_CONVERT) begin
            step_q <= step_q + TIMER_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (reset || !blank_convert_n) begin
            high_q <= '0;
        end else if (!long_high) begin
            high_q <= high_q + TIMER_W'(1);
        end
    end

    // ==========================================================
    // Output decoding
    // ==========================================================
    function automatic logic blank_finish(input abcs_state_type st,
                                          input logic           due,
                                          input logic           bc_n);
        return (st == ABCS_BLANKING) && due && bc_n;
    endfunction

    wire done_set    = sar.finished && in_convert;
    wire leave_blank = blank_finish(state_q, blank_due, blank_convert_n);
    wire drive_set   = (state_q == ABCS_PRESENT) && data_due;

    // Set and clear belong to different states, so they never meet in one cycle.
    always_ff @(posedge clk) begin
        if (reset || leave_blank) begin
            done_q <= 1'b0;
        end else if (done_set) begin
            done_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            result_q <= RESULT_RESET;
        end else if (done_set) begin
            result_q <= sar.result;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || leave_blank) begin
            drive_q <= 1'b0;
        end else if (drive_set) begin
            drive_q <= 1'b1;
        end
    end

    // ==========================================================
    // Pins
    // ==========================================================
    // The done pin only ever pulls low; the pull-up lives outside the chip.
    assign conversion_done_n_out  = 1'b0;
    assign conversion_done_n_oe_n = !done_q;
    assign data_out               = result_q;
    // Every bit shares one enable, so the bus is never half driven.
    generate
        for (genvar g = 0; g < RESULT_W; g++) begin : g_oe
            assign data_oe_n[g] = !drive_q;
        end
    endgenerate
endmodule

//--- verification/abcs_sequencer_props.sv
`timescale 1ns/10ps
// ==========
// Checker
// ==========
module abcs_sequencer_chk import abcs_pkg::*; #(
    parameter int CONV_CYC = 40
) (
    input wire logic                clk,
    input wire logic                reset,
    input wire logic                blank_convert_n,
    input wire logic [RESULT_W-1:0] data_out,
    input wire logic [RESULT_W-1:0] data_oe_n,
    input wire logic                conversion_done_n_out,
    input wire logic                conversion_done_n_oe_n
);
    logic [7:0] hi_q;
    logic [7:0] lo_q;
    // Counters saturate so a long idle spell never wraps into a false window.
    always_ff @(posedge clk) begin
        hi_q <= (reset || !blank_convert_n) ? 8'h00 : hi_q + {7'h00, hi_q != 8'hFF};
        lo_q <= (reset || blank_convert_n) ? 8'h00 : lo_q + {7'h00, lo_q != 8'hFF};
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence s_start; $fell(blank_convert_n); endsequence
    sequence s_frozen;
        ($stable(data_oe_n) && $stable(conversion_done_n_oe_n))[*8];
    endsequence
    a_start_keeps_out: assert property (s_start |=> s_frozen)
        else $error("outputs moved at conversion start");
    a_idle_released: assert property (hi_q >= 8'd70 |-> data_oe_n == '1 && conversion_done_n_oe_n)
        else $error("outputs not released in standby");
    a_halt_no_change: assert property (blank_convert_n && hi_q >= 8'd3 && hi_q < 8'd55
        |-> $stable(data_oe_n) && $stable(conversion_done_n_oe_n))
        else $error("outputs moved while input high");
    a_data_in_time: assert property ($fell(conversion_done_n_oe_n) |-> ##[0:25] data_oe_n == '0)
        else $error("data late after done");
    a_result_held: assert property (lo_q > CONV_CYC + 30
        |-> data_oe_n == '0 && !conversion_done_n_oe_n && $stable(data_out))
        else $error("result not held");
    a_conv_finishes: assert property (lo_q == CONV_CYC + 8 |-> !conversion_done_n_oe_n)
        else $error("conversion did not finish");
    a_done_open_coll: assert property (conversion_done_n_out == 1'b0)
        else $error("done pin drives high");
    a_oe_all_bits: assert property (data_oe_n == '0 || data_oe_n == '1)
        else $error("data enables split");
endmodule
bind abcs_sequencer abcs_sequencer_chk #(.CONV_CYC(CONV_CYC)) i_chk (.clk(clk), .reset(reset),
    .blank_convert_n(blank_convert_n), .data_out(data_out), .data_oe_n(data_oe_n),
    .conversion_done_n_out(conversion_done_n_out),
    .conversion_done_n_oe_n(conversion_done_n_oe_n));

//--- verification/abcs_host_model.sv
`timescale 1ns/10ps
// ==========
// Host start logic
// ==========
module abcs_host_model (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic start_wr,
    input  wire logic park,
    input  wire logic done_pin,
    output logic      blank_convert_n,
    output logic      poll_level,
    output logic      sample_hold
);
    logic ff_q;
    logic done_q;
    // The flip-flop clears itself, so the start pulse is always long enough.
    always_ff @(posedge clk) begin
        ff_q <= !reset && (start_wr || (ff_q && !(done_pin && !done_q)));
        done_q <= done_pin;
    end
    assign blank_convert_n = ff_q | park;
    assign poll_level = done_pin;
    // Hold from the control line going low until the done line falls.
    assign sample_hold = !blank_convert_n && done_pin;
endmodule

//--- verification/testbench.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
    import abcs_pkg::*;
    logic                clk = 0, reset = 1, compare_high = 0, start_wr = 0, park = 1;
    logic                blank_convert_n, poll_level, done_pin, done_out, done_oe_n, oe_prev;
    logic                sample_hold;
    logic [RESULT_W-1:0] data_out, data_oe_n, exp_v, exp_q[$];
    int                  bad_count = 0, n_tests = 0, n;
    integer              seed = 32'hd713;
    assign done_pin = done_oe_n ? 1'b1 : done_out;
    initial forever #10 clk = ~clk;
    abcs_host_model i_abcs_host_model (.clk(clk), .reset(reset), .start_wr(start_wr),
        .park(park), .done_pin(done_pin), .blank_convert_n(blank_convert_n),
        .poll_level(poll_level), .sample_hold(sample_hold));
    abcs_sequencer #(.CONV_CYC(40)) i_abcs_sequencer (.clk(clk), .reset(reset),
        .blank_convert_n(blank_convert_n), .compare_high(compare_high),
        .data_out(data_out), .data_oe_n(data_oe_n), .conversion_done_n_out(done_out),
        .conversion_done_n_oe_n(done_oe_n));
    task automatic test_done();
        if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wait_pin(input logic v, input int lim, output int cnt);
        cnt = 0;
        while (poll_level !== v) begin
            @(posedge clk);
            #1;
            cnt++;
            if (cnt > lim) begin
                bad_count++;
                test_done();
            end
        end
    endtask
    // A constant comparator answer gives all ones or all zeros.
    task automatic convert(input logic by_start);
        logic b;
        b = $random(seed);
        exp_q.push_back({RESULT_W{b}});
        @(posedge clk);
        compare_high <= b;
        if (by_start) start_wr <= 1'b1;
        else park <= 1'b0;
        @(posedge clk);
        start_wr <= 1'b0;
    endtask
    always @(posedge clk) begin
        #1;
        if (data_oe_n[0] === 1'b0 && oe_prev === 1'b1) begin
            exp_v = exp_q.size() ? exp_q.pop_front() : 'x;
            `CHK("result", exp_v, data_out)
            `CHK("done at data", 1'b0, done_pin)
            `CHK("upper word", exp_v[9:2], data_out[9:2])
            `CHK("lower word", exp_v[1:0], data_out[1:0])
            `CHK("sample mode", 1'b0, sample_hold)
        end
        oe_prev = data_oe_n[0];
    end
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (80) @(posedge clk);
        #1;
        `CHK("idle oe", '1, data_oe_n)
        `CHK("idle done", 1'b1, done_pin)
        for (int i = 0; i < 5; i++) begin
            convert(1'b0);
            if (i >= 3) begin
                repeat (20) @(posedge clk);
                park <= 1'b1;
                repeat (i == 3 ? 30 : 110) @(posedge clk);
                #1;
                `CHK("halted done", 1'b1, done_pin)
                @(posedge clk);
                park <= 1'b0;
            end
            wait_pin(1'b0, 200, n);
            if (i >= 3) `CHK("fresh start", i == 4, n >= 38)
            repeat (100) @(posedge clk);
            park <= 1'b1;
            wait_pin(1'b1, 100, n);
            `CHK("release", 1'b1, n >= 60 && n <= 72)
        end
        convert(1'b0);
        wait_pin(1'b0, 200, n);
        repeat (10) @(posedge clk);
        park <= 1'b1;
        repeat (30) @(posedge clk);
        park <= 1'b0;
        repeat (60) @(posedge clk);
        #1;
        `CHK("blank restart", 1'b0, done_pin)
        for (int i = 0; i < 3; i++) begin
            convert(1'b1);
            wait_pin(1'b1, 100, n);
            wait_pin(1'b0, 200, n);
        end
        repeat (5) @(posedge clk);
        `CHK("pending", 0, exp_q.size())
        test_done();
    end
endmodule
